// File: lsd_pkg.sv
// Shared constants for the LED sink shift and latch front end.
// Assumes a single 125 MHz core clock; pins arrive asynchronous to it.
package lsd_pkg;

  // Channel count and shift chain length
  localparam int CHANNELS = 8;

  // Synchroniser depth for pins from the controller
  localparam int SYNC_STAGES = 2;

  // Core clock period in ns (125 MHz)
  localparam int CORE_CLK_PERIOD_NS = 8;

  // Fastest shift clock the controller may use, 20 MHz
  localparam int SHIFT_CLK_MAX_MHZ = 20;

  // Least shift clock period in ns derived from the rate
  localparam int SHIFT_CLK_MIN_PERIOD_NS = 1000 / SHIFT_CLK_MAX_MHZ;

  // Least period in core cycles, rounded up, never below one
  localparam int SHIFT_MIN_CYCLES_RAW =
    (SHIFT_CLK_MIN_PERIOD_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;
  localparam int SHIFT_MIN_CYCLES = (SHIFT_MIN_CYCLES_RAW < 1) ? 1 : SHIFT_MIN_CYCLES_RAW;

  // Width of the spacing counter
  localparam int SPACING_W = 4;

  // Reset values of the data path
  localparam logic [CHANNELS-1:0] SHIFT_RESET = 8'h00;
  localparam logic [CHANNELS-1:0] LATCH_RESET = 8'h00;
  localparam logic [CHANNELS-1:0] SINKS_OFF = 8'h00;

endpackage : lsd_pkg

// File: lsd_sync2.sv
// Two flip-flop synchroniser for a group of asynchronous pins.
// Assumes each bit is an independent level; no bus coherence is promised.
module lsd_sync2 #(
  parameter int WIDTH = 4
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  // First stage, read only by the second stage
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  // Second stage, safe for logic
  logic [WIDTH-1:0] stable;
  logic [WIDTH-1:0] next_stable;

  // Next values of both stages
  always_comb begin
    next_meta = i_async;
    next_stable = meta;
  end

  // Register both stages; reset clears them to a known level
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      meta <= '0;
      stable <= '0;
    end else begin
      meta <= next_meta;
      stable <= next_stable;
    end
  end

  assign o_sync = stable;

endmodule // lsd_sync2

// File: lsd_shift_latch.sv
// LED sink front end: serial shift chain, level latch and output gating.
// Assumes the controller drives shift clock, data, strobe and enable as
// asynchronous pins; all are sampled on the core clock.
// Operation
// - Eight-stage shift chain advances per clock rise
// - First stage loads serial input on rise
// - Last stage drives serial output for cascading
// - Shifting happens on the rising clock edge
// - Latch is level sensitive, strobe controlled only
// - Strobe low: latch holds its stored value
// - Strobe high: latch follows shift chain continuously
// - Enable high turns every sink off
// - Enable low: each sink gated by its bit
// - Latched one turns sink on, zero off
module lsd_shift_latch #(
  parameter int CHANNELS = lsd_pkg::CHANNELS
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_shift_clk,
  input wire logic i_serial_in,
  input wire logic i_latch_strobe,
  input wire logic i_output_enable_n,
  output logic o_serial_out,
  output logic [CHANNELS-1:0] o_led_sink_outputs,
  output logic o_rate_error
);

  // Pin group order inside the synchroniser
  localparam int PIN_CLK = 0;
  localparam int PIN_DATA = 1;
  localparam int PIN_STROBE = 2;
  localparam int PIN_EN_N = 3;

  // Spacing threshold at counter width
  localparam logic [lsd_pkg::SPACING_W-1:0] MIN_GAP =
    (lsd_pkg::SPACING_W)'(lsd_pkg::SHIFT_MIN_CYCLES);
  // Counter saturation value
  localparam logic [lsd_pkg::SPACING_W-1:0] GAP_MAX = '1;

  // Synchronised pin levels
  logic [3:0] pins_sync;
  logic clk_s;
  logic data_s;
  logic strobe_s;
  logic en_n_s;

  // Delayed shift clock for edge detection
  logic clk_d;
  logic next_clk_d;
  // Rising edge of the shift clock, one cycle wide
  logic shift_rise;

  // Shift chain and its next value
  logic [CHANNELS-1:0] shift_reg;
  logic [CHANNELS-1:0] next_shift_reg;
  // Serial tap register
  logic next_serial_out;

  // Level latch contents
  logic [CHANNELS-1:0] latch_q;
  logic [CHANNELS-1:0] next_latch_q;
  // Gated sink drive
  logic [CHANNELS-1:0] next_sinks;

  // Spacing monitor between shift clock rises
  logic [lsd_pkg::SPACING_W-1:0] gap_cnt;
  logic [lsd_pkg::SPACING_W-1:0] next_gap_cnt;
  logic seen_rise;
  logic next_seen_rise;
  logic next_rate_error;

  // Every pin is asynchronous to the core clock
  lsd_sync2 #(
    .WIDTH(4)
  ) u_pin_sync (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_async({i_output_enable_n, i_latch_strobe, i_serial_in, i_shift_clk}),
    .o_sync(pins_sync)
  );

  // Split the synchronised group; data and clock share one delay
  always_comb begin
    clk_s = pins_sync[PIN_CLK];
    data_s = pins_sync[PIN_DATA];
    strobe_s = pins_sync[PIN_STROBE];
    en_n_s = pins_sync[PIN_EN_N];
  end

  // Edge detector on the second stage only
  always_comb begin
    next_clk_d = clk_s;
    shift_rise = clk_s & ~clk_d;
  end

  // Shift chain: move up one place per rise, enter new bit at the bottom
  always_comb begin
    next_shift_reg = shift_reg;
    if (shift_rise) begin
      next_shift_reg = {shift_reg[CHANNELS-2:0], data_s};
    end
    // Top stage is the cascade tap
    next_serial_out = next_shift_reg[CHANNELS-1];
  end

  // Latch is a level gate: open while strobe is high, frozen while low.
  // Using the next chain value keeps the outputs in step with the chain
  // instead of trailing by one more cycle.
  always_comb begin
    if (strobe_s) begin
      next_latch_q = next_shift_reg;
    end else begin
      next_latch_q = latch_q;
    end
  end

  // Per-channel AND of latched bits with the inverted enable
  always_comb begin
    next_sinks = next_latch_q & {CHANNELS{~en_n_s}};
  end

  // Spacing counter; a rise sooner than the least period is flagged.
  // Only a diagnostic: shifting still follows the controller.
  always_comb begin
    next_gap_cnt = gap_cnt;
    next_seen_rise = seen_rise;
    next_rate_error = 1'b0;
    if (shift_rise) begin
      // Too close to the previous rise
      if (seen_rise && (gap_cnt < MIN_GAP)) begin
        next_rate_error = 1'b1;
      end
      // Restart the count at one cycle since this rise
      next_gap_cnt = (lsd_pkg::SPACING_W)'(1);
      next_seen_rise = 1'b1;
    end else if (gap_cnt != GAP_MAX) begin
      // Saturate so long pauses never wrap
      next_gap_cnt = gap_cnt + (lsd_pkg::SPACING_W)'(1);
    end
  end

  // Register all state. Reset gives known data only as a convenience; the
  // pins carry no reset, so software must still shift and latch a frame.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      clk_d <= 1'b0;
      shift_reg <= lsd_pkg::SHIFT_RESET;
      o_serial_out <= 1'b0;
      latch_q <= lsd_pkg::LATCH_RESET;
      o_led_sink_outputs <= lsd_pkg::SINKS_OFF;
      gap_cnt <= '0;
      seen_rise <= 1'b0;
      o_rate_error <= 1'b0;
    end else begin
      clk_d <= next_clk_d;
      shift_reg <= next_shift_reg;
      o_serial_out <= next_serial_out;
      latch_q <= next_latch_q;
      o_led_sink_outputs <= next_sinks;
      gap_cnt <= next_gap_cnt;
      seen_rise <= next_seen_rise;
      o_rate_error <= next_rate_error;
    end
  end

  // Checks on the core clock domain
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  // Count of rises since reset, saturating, for the full-byte checks
  logic [3:0] rise_count;
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      rise_count <= 4'h0;
    end else if (shift_rise && (rise_count != 4'hf)) begin
      rise_count <= rise_count + 4'h1;
    end
  end

  // Chain moves up one place on a rise
  property p_shift_advance;
    shift_rise |=> (shift_reg[CHANNELS-1:1] == $past(shift_reg[CHANNELS-2:0]));
  endproperty
  a_shift_advance: assert property (p_shift_advance)
    else $error("Shift chain did not advance on clock rise");

  // Bottom stage takes the data pin level seen with the rise
  property p_shift_load;
    shift_rise |=> (shift_reg[0] == $past(data_s));
  endproperty
  a_shift_load: assert property (p_shift_load)
    else $error("First stage did not load serial input");

  // Serial output carries the bit below the top after a rise
  property p_serial_tap;
    shift_rise |=> (o_serial_out == $past(shift_reg[CHANNELS-2]));
  endproperty
  a_serial_tap: assert property (p_serial_tap)
    else $error("Serial output not the last stage");

  // Pin rise reaches the chain exactly three core edges later
  property p_rise_latency;
    (!clk_s && !clk_d) ##1 clk_s |=> !$stable(rise_count) or (rise_count == 4'hf);
  endproperty
  a_rise_latency: assert property (p_rise_latency)
    else $error("Shift not taken on rising edge");

  // Without a rise the chain holds
  property p_no_rise_hold;
    !shift_rise |=> $stable(shift_reg);
  endproperty
  a_no_rise_hold: assert property (p_no_rise_hold)
    else $error("Shift chain moved without a rise");

  // Strobe low for two cycles keeps the latch across shifts
  property p_latch_hold;
    !strobe_s ##1 !strobe_s |-> $stable(latch_q);
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("Latch changed while strobe low");

  // Strobe held high: latch tracks every shift, not only the first
  property p_latch_follow;
    strobe_s [*2] |=> (latch_q == shift_reg);
  endproperty
  a_latch_follow: assert property (p_latch_follow)
    else $error("Latch not transparent while strobe high");

  // Enable high blanks all sinks on the next edge
  property p_blank;
    en_n_s |=> (o_led_sink_outputs == lsd_pkg::SINKS_OFF);
  endproperty
  a_blank: assert property (p_blank)
    else $error("Sinks on while enable high");

  // Enable low passes latched bits, one to on and zero to off
  property p_gate;
    !en_n_s |=> (o_led_sink_outputs == latch_q);
  endproperty
  a_gate: assert property (p_gate)
    else $error("Sinks not following latched bits");

  // Transparent and enabled: sinks match the chain
  property p_polarity;
    (!en_n_s && strobe_s) |=> (o_led_sink_outputs == shift_reg);
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("Sink polarity wrong");

  // At reset release with strobe low, sinks are off
  property p_reset_dark;
    $rose(i_rst_n) ##0 !strobe_s |-> (o_led_sink_outputs == lsd_pkg::SINKS_OFF);
  endproperty
  a_reset_dark: assert property (p_reset_dark)
    else $error("Sinks lit straight after reset");

  // A full byte shifted then latched
  c_byte_latched: cover property (rise_count == 4'h8 ##[1:100] strobe_s);
  // Blanking applied to lit outputs
  c_blanking: cover property ((o_led_sink_outputs != 8'h00) ##1 en_n_s);
  // Controller running too fast
  c_rate_error: cover property (o_rate_error);

endmodule // lsd_shift_latch

// File: lsd_ctrl_model.sv
// Controller model: drives shift clock, data, strobe and enable pins.
// Assumes the core clock is free running; pins move on its falling edge.
module lsd_ctrl_model (
  input wire logic i_core_clk,
  output logic o_shift_clk,
  output logic o_serial_in,
  output logic o_latch_strobe,
  output logic o_output_enable_n
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle levels: strobe pulled low, enable pulled high
  initial begin
    o_shift_clk = 1'b0;
    o_serial_in = 1'b0;
    o_latch_strobe = 1'b0;
    o_output_enable_n = 1'b1;
  end

  // Waits whole core cycles, falling edge to falling edge
  task automatic wait_fall(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask

  // Data settles two cycles ahead, then clock high and low for half each
  // Half of 4 keeps rises 10 cycles apart; half of 2 breaks the rate on purpose
  task automatic shift_bit(input logic bit_val, input int half);
    o_serial_in = bit_val;
    wait_fall(2);
    o_shift_clk = 1'b1;
    wait_fall(half);
    o_shift_clk = 1'b0;
    wait_fall(half);
  endtask

  // Top bit goes first so it lands in the last stage
  task automatic shift_byte(input logic [7:0] b, input int half);
    for (int i = 7; i >= 0; i--) begin
      shift_bit(b[i], half);
    end
  endtask

  task automatic set_strobe(input logic v);
    o_latch_strobe = v;
  endtask

  task automatic set_enable_n(input logic v);
    o_output_enable_n = v;
  endtask
endmodule // lsd_ctrl_model

// File: test_lsd_shift_latch.sv
// Self-checking bench for the shift, latch and sink gating front end.
// Assumes the controller model drives every pin; bench owns clock and reset.
module test_lsd_shift_latch;
  timeunit 1ns;
  timeprecision 1ps;

  logic i_core_clk = 1'b0;
  logic i_rst_n; // Driven only by the main sequence
  logic shift_clk, serial_in, latch_strobe, output_enable_n;
  logic o_serial_out;
  logic [7:0] o_led_sink_outputs;
  logic o_rate_error;
  int fails = 0;
  int tests_run = 0;
  int cycles = 0;
  int rate_pulses = 0; // Spacing pulses seen so far

  // 125 MHz core clock
  always #4 i_core_clk = ~i_core_clk;

  lsd_shift_latch lsd_shift_latch_i (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_shift_clk(shift_clk),
    .i_serial_in(serial_in),
    .i_latch_strobe(latch_strobe),
    .i_output_enable_n(output_enable_n),
    .o_serial_out(o_serial_out),
    .o_led_sink_outputs(o_led_sink_outputs),
    .o_rate_error(o_rate_error)
  );

  lsd_ctrl_model lsd_ctrl_model_i (
    .i_core_clk(i_core_clk),
    .o_shift_clk(shift_clk),
    .o_serial_in(serial_in),
    .o_latch_strobe(latch_strobe),
    .o_output_enable_n(output_enable_n)
  );

  // Pulse counter and hang guard; a full run needs about 450 cycles.
  // Sampled on the falling edge so the registered pulse has settled.
  always @(negedge i_core_clk) begin
    cycles++;
    if (o_rate_error === 1'b1) begin
      rate_pulses++;
    end
    if (cycles == 5000) begin
      fails++;
      summarize();
    end
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] expv);
    tests_run++;
    if (seen !== expv) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, expv, seen);
    end
  endtask

  task automatic summarize();
    if (fails == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Three edges of pipeline plus margin
  task automatic settle();
    lsd_ctrl_model_i.wait_fall(6);
  endtask

  // Cleared state straight after reset
  task automatic t_reset();
    check("sinks after reset", o_led_sink_outputs, 8'h00);
    check("serial out after reset", {7'h00, o_serial_out}, 8'h00);
  endtask

  // Transparent latch, enabled sinks, legal rate
  task automatic t_shift_transparent();
    int p0;
    p0 = rate_pulses;
    lsd_ctrl_model_i.set_enable_n(1'b0);
    lsd_ctrl_model_i.set_strobe(1'b1);
    lsd_ctrl_model_i.shift_byte(8'ha5, 4);
    settle();
    check("sinks follow chain", o_led_sink_outputs, 8'ha5);
    check("cascade bit", {7'h00, o_serial_out}, 8'h01);
    check("no rate pulse", 8'(rate_pulses - p0), 8'h00);
  endtask

  // Strobe low freezes, strobe high passes the chain again
  task automatic t_hold();
    lsd_ctrl_model_i.set_strobe(1'b0);
    lsd_ctrl_model_i.shift_byte(8'h5a, 4);
    settle();
    check("held sinks", o_led_sink_outputs, 8'ha5);
    check("cascade while held", {7'h00, o_serial_out}, 8'h00);
    lsd_ctrl_model_i.set_strobe(1'b1);
    settle();
    check("released sinks", o_led_sink_outputs, 8'h5a);
    // One more bit with strobe still high moves the sinks too
    lsd_ctrl_model_i.shift_bit(1'b1, 4);
    settle();
    check("level latch", o_led_sink_outputs, 8'hb5);
    check("cascade next bit", {7'h00, o_serial_out}, 8'h01);
  endtask

  // Enable high blanks every sink, low restores the latched bits
  task automatic t_enable();
    lsd_ctrl_model_i.set_enable_n(1'b1);
    settle();
    check("sinks disabled", o_led_sink_outputs, 8'h00);
    lsd_ctrl_model_i.set_enable_n(1'b0);
    settle();
    check("sinks enabled", o_led_sink_outputs, 8'hb5);
  endtask

  // Too-fast rises still shift but each close rise is flagged
  task automatic t_fast();
    int p0;
    p0 = rate_pulses;
    lsd_ctrl_model_i.shift_byte(8'h0f, 2);
    settle();
    check("fast shift sinks", o_led_sink_outputs, 8'h0f);
    check("rate pulses", 8'(rate_pulses - p0), 8'h07);
    lsd_ctrl_model_i.shift_byte(8'hff, 4);
    settle();
    check("all sinks on", o_led_sink_outputs, 8'hff);
  endtask

  // Reset in mid-run clears chain and sinks; a fresh frame then lands
  task automatic t_reset_mid();
    i_rst_n = 1'b0;
    lsd_ctrl_model_i.wait_fall(6);
    i_rst_n = 1'b1;
    lsd_ctrl_model_i.wait_fall(1);
    check("sinks after mid reset", o_led_sink_outputs, 8'h00);
    check("serial out after mid reset", {7'h00, o_serial_out}, 8'h00);
    lsd_ctrl_model_i.shift_byte(8'h3c, 4);
    settle();
    check("frame after mid reset", o_led_sink_outputs, 8'h3c);
    check("cascade after mid reset", {7'h00, o_serial_out}, 8'h00);
  endtask

  // Main sequence
  initial begin
    i_rst_n = 1'b0;
    repeat (6) @(negedge i_core_clk);
    i_rst_n = 1'b1;
    @(negedge i_core_clk);
    t_reset();
    t_shift_transparent();
    t_hold();
    t_enable();
    t_fast();
    t_reset_mid();
    summarize();
  end
endmodule // test_lsd_shift_latch
